// >>> hw/gia_guard.sv
// APB register block: interrupt modes, output write mask and write guard
`timescale 1ns/1ns
module gia_guard #(
  parameter int NUM_LINES = 32
) (
  input  wire logic                 pclk,
  input  wire logic                 presetn,
  input  wire logic                 psel,
  input  wire logic                 penable,
  input  wire logic                 pwrite,
  input  wire logic [31:0]          paddr,
  input  wire logic [31:0]          pwdata,
  output logic      [31:0]          prdata,
  output logic                      pready,
  output logic                      pslverr,
  input  wire logic [NUM_LINES-1:0] line_in,
  input  wire logic [NUM_LINES-1:0] line_lock,
  output logic      [NUM_LINES-1:0] line_out,
  output logic      [NUM_LINES-1:0] pull_down_en,
  output logic                      irq
);

  // ****************************************************************
  // Elaboration check
  // ****************************************************************
  // Lines beyond one bus word would have no room in the registers
  if (NUM_LINES < 1 || NUM_LINES > gia_pkg::MAX_LINES) begin : g_bad_lines
    $error("NUM_LINES must lie between 1 and 32");
  end

  // Zero fill above the last line in every per-line read word
  localparam int PAD = gia_pkg::MAX_LINES - NUM_LINES;

  // ****************************************************************
  // Declarations
  // ****************************************************************
  // Decode and read path
  gia_pkg::gia_apb_req_t     req;
  gia_pkg::gia_guard_status_t gstat;
  logic                      access;
  logic                      wr_acc;
  logic                      rd_acc;
  logic                      mapped;
  logic                      prot_target;
  logic                      blocked;
  logic                      wr_ok;
  logic [31:0]               rd_word;
  logic [31:0]               nxt_prdata;
  logic [15:0]               nxt_source;
  logic [NUM_LINES-1:0]      wbits;
  logic [NUM_LINES-1:0]      line_event;
  logic                      key_ok;

  // State registers, one process each
  logic [NUM_LINES-1:0]      xmode_ff;
  logic [NUM_LINES-1:0]      level_ff;
  logic [NUM_LINES-1:0]      high_ff;
  logic [NUM_LINES-1:0]      ow_en_ff;
  logic [NUM_LINES-1:0]      pd_dis_ff;
  logic [NUM_LINES-1:0]      out_data_ff;
  logic [NUM_LINES-1:0]      irq_stat_ff;
  logic [NUM_LINES-1:0]      irq_en_ff;

  // Write guard state
  logic                      guard_en_ff;
  logic                      viol_flag_ff;
  logic [15:0]               viol_src_ff;

  // Bus-side output registers
  logic [31:0]               prdata_ff;
  logic                      slverr_ff;

  // ****************************************************************
  // APB decode
  // ****************************************************************
  // Zero-wait slave: every access completes in its first access cycle
  assign req.addr  = paddr;
  assign req.write = pwrite;
  assign req.wdata = pwdata;
  assign access    = psel & penable;
  assign wr_acc    = access & req.write;
  assign rd_acc    = access & ~req.write;

  // Per-line write bits; word bits above the last line are ignored
  assign wbits     = req.wdata[NUM_LINES-1:0];

  // No wait states, so a transfer never stalls the master
  assign pready    = 1'b1;

  // Registers that refuse writes while protection is on
  always_comb begin
    case (req.addr)
      gia_pkg::ADDR_PD_DISABLE,
      gia_pkg::ADDR_PD_ENABLE,
      gia_pkg::ADDR_OW_ENABLE,
      gia_pkg::ADDR_OW_DISABLE: prot_target = 1'b1;
      // Mode, guard and interrupt registers are never guarded
      default:                  prot_target = 1'b0;
    endcase
  end

  // A blocked write still ends normally on the bus, without error
  assign blocked = wr_acc & prot_target & guard_en_ff;
  assign wr_ok   = wr_acc & ~blocked;

  // Offset of the blocked access relative to the port base
  assign nxt_source = 16'(req.addr - gia_pkg::BASE_ADDR);

  // ****************************************************************
  // Interrupt mode state
  // ****************************************************************
  // Set and clear are separate writes; each acts only on lines written as one
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      xmode_ff <= '0;
    end else if (wr_ok && req.addr == gia_pkg::ADDR_XMODE_SET) begin
      xmode_ff <= xmode_ff | wbits;
    end else if (wr_ok && req.addr == gia_pkg::ADDR_XMODE_CLEAR) begin
      xmode_ff <= xmode_ff & ~wbits;
    end
  end

  // Edge or level selection, zero meaning edge
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      level_ff <= '0;
    end else if (wr_ok && req.addr == gia_pkg::ADDR_EDGE_PICK) begin
      level_ff <= level_ff & ~wbits;
    end else if (wr_ok && req.addr == gia_pkg::ADDR_LEVEL_PICK) begin
      level_ff <= level_ff | wbits;
    end
  end

  // Polarity selection, zero meaning falling or low
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      high_ff <= '0;
    end else if (wr_ok && req.addr == gia_pkg::ADDR_LOW_PICK) begin
      high_ff <= high_ff & ~wbits;
    end else if (wr_ok && req.addr == gia_pkg::ADDR_HIGH_PICK) begin
      high_ff <= high_ff | wbits;
    end
  end

  // ****************************************************************
  // Protected pad and output write mask
  // ****************************************************************
  // Output write mask; a blocked write never reaches it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ow_en_ff <= '0;
    end else if (wr_ok && req.addr == gia_pkg::ADDR_OW_ENABLE) begin
      ow_en_ff <= ow_en_ff | wbits;
    end else if (wr_ok && req.addr == gia_pkg::ADDR_OW_DISABLE) begin
      ow_en_ff <= ow_en_ff & ~wbits;
    end
  end

  // Pull-down disable mask, pull-downs on after reset
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pd_dis_ff <= '0;
    end else if (wr_ok && req.addr == gia_pkg::ADDR_PD_DISABLE) begin
      pd_dis_ff <= pd_dis_ff | wbits;
    end else if (wr_ok && req.addr == gia_pkg::ADDR_PD_ENABLE) begin
      pd_dis_ff <= pd_dis_ff & ~wbits;
    end
  end

  // Output data: only lines enabled in the write mask change
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      out_data_ff <= '0;
    end else if (wr_ok && req.addr == gia_pkg::ADDR_OUT_DATA) begin
      out_data_ff <= (out_data_ff & ~ow_en_ff) | (wbits & ow_en_ff);
    end
  end

  // Pin-side outputs straight from flops, so they never glitch
  assign line_out     = out_data_ff;
  assign pull_down_en = ~pd_dis_ff;

  // ****************************************************************
  // Write guard
  // ****************************************************************
  // Key match; a wrong key is dropped quietly and is no violation
  assign key_ok = (req.wdata[31:gia_pkg::GUARD_KEY_LSB] == gia_pkg::GUARD_KEY_VALUE);

  // Enable changes only with the matching key in bits 31:8
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      guard_en_ff <= gia_pkg::RESET_BIT;
    end else if (wr_acc && req.addr == gia_pkg::ADDR_GUARD_MODE && key_ok) begin
      guard_en_ff <= req.wdata[gia_pkg::GUARD_EN_BIT];
    end
  end

  // Violation flag: a new violation wins over the clearing read
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      viol_flag_ff <= gia_pkg::RESET_BIT;
    end else if (blocked) begin
      viol_flag_ff <= 1'b1;
    end else if (rd_acc && req.addr == gia_pkg::ADDR_GUARD_STATUS) begin
      viol_flag_ff <= 1'b0;
    end
  end

  // Source follows the latest blocked write
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      viol_src_ff <= '0;
    end else if (blocked) begin
      viol_src_ff <= nxt_source;
    end
  end

  // Status word; source is shown only while the flag is up
  always_comb begin
    gstat        = '0;
    gstat.flag   = viol_flag_ff;
    gstat.source = viol_flag_ff ? viol_src_ff : 16'h0000;
  end

  // ****************************************************************
  // Line interrupts
  // ****************************************************************
  // A mode write acts on events from the cycle after it lands
  gia_irq_detect #(
    .NUM_LINES  (NUM_LINES)
  ) u_detect (
    .pclk       (pclk),
    .presetn    (presetn),
    .line_in    (line_in),
    .extra_mode (xmode_ff),
    .level_mode (level_ff),
    .high_pol   (high_ff),
    .line_event (line_event)
  );

  // Sticky status; an event in the clear cycle is kept
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_stat_ff <= '0;
    end else if (wr_acc && req.addr == gia_pkg::ADDR_IRQ_CLEAR) begin
      irq_stat_ff <= (irq_stat_ff & ~wbits) | line_event;
    end else begin
      irq_stat_ff <= irq_stat_ff | line_event;
    end
  end

  // Interrupt enable mask
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_en_ff <= '0;
    end else if (wr_acc && req.addr == gia_pkg::ADDR_IRQ_ENABLE) begin
      irq_en_ff <= wbits;
    end
  end

  // Level output, high while any enabled status bit is set
  assign irq = |(irq_stat_ff & irq_en_ff);

  // ****************************************************************
  // Read mux
  // ****************************************************************
  // Write-only registers read as zero but are still mapped
  always_comb begin
    mapped  = 1'b1;
    rd_word = '0;
    case (req.addr)
      gia_pkg::ADDR_PD_STATE:     rd_word = {{PAD{1'b0}}, pd_dis_ff};
      gia_pkg::ADDR_OW_STATE:     rd_word = {{PAD{1'b0}}, ow_en_ff};
      gia_pkg::ADDR_XMODE_STATE:  rd_word = {{PAD{1'b0}}, xmode_ff};
      gia_pkg::ADDR_EL_STATE:     rd_word = {{PAD{1'b0}}, level_ff};
      gia_pkg::ADDR_POL_STATE:    rd_word = {{PAD{1'b0}}, high_ff};
      gia_pkg::ADDR_LOCK_STATE:   rd_word = {{PAD{1'b0}}, line_lock};
      gia_pkg::ADDR_GUARD_MODE:   rd_word = {31'h00000000, guard_en_ff};
      gia_pkg::ADDR_GUARD_STATUS: rd_word = gstat;
      gia_pkg::ADDR_OUT_DATA:     rd_word = {{PAD{1'b0}}, out_data_ff};
      gia_pkg::ADDR_IRQ_STATUS:   rd_word = {{PAD{1'b0}}, irq_stat_ff};
      gia_pkg::ADDR_IRQ_ENABLE:   rd_word = {{PAD{1'b0}}, irq_en_ff};
      // Write-only registers read as zero and raise no error
      gia_pkg::ADDR_PD_DISABLE,
      gia_pkg::ADDR_PD_ENABLE,
      gia_pkg::ADDR_OW_ENABLE,
      gia_pkg::ADDR_OW_DISABLE,
      gia_pkg::ADDR_XMODE_SET,
      gia_pkg::ADDR_XMODE_CLEAR,
      gia_pkg::ADDR_EDGE_PICK,
      gia_pkg::ADDR_LEVEL_PICK,
      gia_pkg::ADDR_LOW_PICK,
      gia_pkg::ADDR_HIGH_PICK,
      gia_pkg::ADDR_IRQ_CLEAR:    rd_word = '0;
      default:                    mapped  = 1'b0;
    endcase
  end

  // Read data is captured in the setup cycle and shown in the access cycle
  assign nxt_prdata = (psel && !penable && !pwrite) ? rd_word : prdata_ff;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_ff <= gia_pkg::RESET_WORD;
    end else begin
      prdata_ff <= nxt_prdata;
    end
  end

  // Error flag also registered in setup, so it is stable in access
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      slverr_ff <= 1'b0;
    end else if (psel && !penable) begin
      slverr_ff <= ~mapped;
    end
  end

  // ****************************************************************
  // Bus outputs
  // ****************************************************************
  // Error shows only in the access phase, never in setup or idle
  assign prdata  = prdata_ff;
  assign pslverr = slverr_ff & access;

endmodule // gia_guard

// >>> hw/gia_pkg.sv
// Package of constants and types for the interrupt-mode and write-guard block
package gia_pkg;

  // ****************************************************************
  // Register map (byte addresses)
  // ****************************************************************
  localparam logic [31:0] BASE_ADDR           = 32'h400e0e00;
  localparam logic [31:0] ADDR_PD_DISABLE     = 32'h400e0e90;
  localparam logic [31:0] ADDR_PD_ENABLE      = 32'h400e0e94;
  localparam logic [31:0] ADDR_PD_STATE       = 32'h400e0e98;
  localparam logic [31:0] ADDR_OW_ENABLE      = 32'h400e0ea0;
  localparam logic [31:0] ADDR_OW_DISABLE     = 32'h400e0ea4;
  localparam logic [31:0] ADDR_OW_STATE       = 32'h400e0ea8;
  localparam logic [31:0] ADDR_XMODE_SET      = 32'h400e0eb0;
  localparam logic [31:0] ADDR_XMODE_CLEAR    = 32'h400e0eb4;
  localparam logic [31:0] ADDR_XMODE_STATE    = 32'h400e0eb8;
  localparam logic [31:0] ADDR_EDGE_PICK      = 32'h400e0ec0;
  localparam logic [31:0] ADDR_LEVEL_PICK     = 32'h400e0ec4;
  localparam logic [31:0] ADDR_EL_STATE       = 32'h400e0ec8;
  localparam logic [31:0] ADDR_LOW_PICK       = 32'h400e0ed0;
  localparam logic [31:0] ADDR_HIGH_PICK      = 32'h400e0ed4;
  localparam logic [31:0] ADDR_POL_STATE      = 32'h400e0ed8;
  localparam logic [31:0] ADDR_LOCK_STATE     = 32'h400e0ee0;
  localparam logic [31:0] ADDR_GUARD_MODE     = 32'h400e0ee4;
  localparam logic [31:0] ADDR_GUARD_STATUS   = 32'h400e0ee8;
  localparam logic [31:0] ADDR_OUT_DATA       = 32'h400e0ef0;
  localparam logic [31:0] ADDR_IRQ_STATUS     = 32'h400e0ef4;
  localparam logic [31:0] ADDR_IRQ_ENABLE     = 32'h400e0ef8;
  localparam logic [31:0] ADDR_IRQ_CLEAR      = 32'h400e0efc;

  // ****************************************************************
  // Field layout and values
  // ****************************************************************
  localparam int          GUARD_EN_BIT        = 0;
  localparam int          GUARD_KEY_LSB       = 8;
  localparam logic [23:0] GUARD_KEY_VALUE     = 24'h50494f;
  localparam logic [31:0] RESET_WORD          = 32'h00000000;
  localparam logic        RESET_BIT           = 1'h0;
  localparam int          MAX_LINES           = 32;

  // Write-guard status word as software sees it
  typedef struct packed {
    logic [7:0]  rsv_hi;
    logic [15:0] source;
    logic [6:0]  rsv_lo;
    logic        flag;
  } gia_guard_status_t;

  // One APB request as sampled in the access phase
  typedef struct packed {
    logic [31:0] addr;
    logic        write;
    logic [31:0] wdata;
  } gia_apb_req_t;

endpackage

// >>> hw/gia_irq_detect.sv
// Per-line interrupt event detector for all five detection modes
`timescale 1ns/1ns
module gia_irq_detect #(
  parameter int NUM_LINES = 32
) (
  input  wire logic                 pclk,
  input  wire logic                 presetn,
  input  wire logic [NUM_LINES-1:0] line_in,
  input  wire logic [NUM_LINES-1:0] extra_mode,
  input  wire logic [NUM_LINES-1:0] level_mode,
  input  wire logic [NUM_LINES-1:0] high_pol,
  output logic      [NUM_LINES-1:0] line_event
);

  logic [NUM_LINES-1:0] prev_ff;
  logic [NUM_LINES-1:0] rise;
  logic [NUM_LINES-1:0] fall;

  // ****************************************************************
  // Previous line value
  // ****************************************************************
  // Lines reset low, so a line high at reset shows one rising edge
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prev_ff <= '0;
    end else begin
      prev_ff <= line_in;
    end
  end

  // Edges and event selection per line
  always_comb begin
    rise = line_in & ~prev_ff;
    fall = ~line_in & prev_ff;
    for (int i = 0; i < NUM_LINES; i++) begin
      if (!extra_mode[i]) begin
        line_event[i] = rise[i] | fall[i];
      end else if (level_mode[i]) begin
        line_event[i] = high_pol[i] ? line_in[i] : ~line_in[i];
      end else begin
        line_event[i] = high_pol[i] ? rise[i] : fall[i];
      end
    end
  end

endmodule // gia_irq_detect

// >>> tb/gia_pins.sv
// Pin-side model of the port: line levels and lock state seen by the block
`timescale 1ns/1ns
module gia_pins (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic [31:0] drive_val,
  input  wire logic [31:0] lock_val,
  output logic      [31:0] line_in,
  output logic      [31:0] line_lock
);
  // Levels change only on a clock edge, like a synchronised pad input
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      line_in   <= 32'h0;
      line_lock <= 32'h0;
    end else begin
      line_in   <= drive_val;
      line_lock <= lock_val;
    end
  end
endmodule // gia_pins

// >>> tb/gia_guard_sva.sv
// Port-level checker for the interrupt-mode and write-guard block
`timescale 1ns/1ns
module gia_guard_sva #(
  parameter int NUM_LINES = 32
) (
  input  wire logic                 pclk,
  input  wire logic                 presetn,
  input  wire logic                 psel,
  input  wire logic                 penable,
  input  wire logic                 pwrite,
  input  wire logic [31:0]          paddr,
  input  wire logic [31:0]          pwdata,
  input  wire logic [31:0]          prdata,
  input  wire logic                 pready,
  input  wire logic                 pslverr,
  input  wire logic [NUM_LINES-1:0] line_lock,
  input  wire logic [NUM_LINES-1:0] line_out,
  input  wire logic [NUM_LINES-1:0] pull_down_en
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // ****************************************************************
  // Shadow of guard enable and output write mask
  // ****************************************************************
  logic                 acc_wr;
  logic                 acc_rd;
  logic                 guard_on_ff;
  logic [NUM_LINES-1:0] ow_ff;
  assign acc_wr = psel && penable && pwrite;
  assign acc_rd = psel && penable && !pwrite;
  // Guard bit moves only with the right key
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      guard_on_ff <= 1'b0;
    end else if (acc_wr && paddr == gia_pkg::ADDR_GUARD_MODE &&
                 pwdata[31:8] == gia_pkg::GUARD_KEY_VALUE) begin
      guard_on_ff <= pwdata[0];
    end
  end
  // Mask writes are dropped while guarded
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ow_ff <= '0;
    end else if (acc_wr && !guard_on_ff && paddr == gia_pkg::ADDR_OW_ENABLE) begin
      ow_ff <= ow_ff | pwdata[NUM_LINES-1:0];
    end else if (acc_wr && !guard_on_ff && paddr == gia_pkg::ADDR_OW_DISABLE) begin
      ow_ff <= ow_ff & ~pwdata[NUM_LINES-1:0];
    end
  end
  chk_ready_high: assert property (pready)
    else $error("pready low");
  chk_err_access: assert property (pslverr |-> psel && penable)
    else $error("pslverr outside access");
  chk_guard_read: assert property (
    acc_rd && paddr == gia_pkg::ADDR_GUARD_MODE
    |-> prdata == {31'h0, guard_on_ff}) else $error("guard mode read");
  chk_lock_read: assert property (
    acc_rd && paddr == gia_pkg::ADDR_LOCK_STATE && $stable(line_lock)
    |-> prdata[NUM_LINES-1:0] == line_lock) else $error("lock read");
  chk_src_idle: assert property (
    acc_rd && paddr == gia_pkg::ADDR_GUARD_STATUS && !prdata[0]
    |-> prdata == 32'h0) else $error("source not zero");
  chk_status_rsv: assert property (
    acc_rd && paddr == gia_pkg::ADDR_GUARD_STATUS |-> prdata[31:24] == 8'h0 && prdata[7:1] == 7'h0)
    else $error("status reserved bits");
  chk_pd_blocked: assert property (
    acc_wr && guard_on_ff &&
    (paddr == gia_pkg::ADDR_PD_ENABLE || paddr == gia_pkg::ADDR_PD_DISABLE)
    |=> $stable(pull_down_en)) else $error("pull-down changed while guarded");
  chk_pd_enable: assert property (
    acc_wr && !guard_on_ff && paddr == gia_pkg::ADDR_PD_ENABLE
    |=> (~pull_down_en & $past(pwdata[NUM_LINES-1:0])) == '0) else $error("pull-down enable lost");
  chk_out_mask: assert property (
    acc_wr && paddr == gia_pkg::ADDR_OUT_DATA |=> line_out ==
    (($past(pwdata[NUM_LINES-1:0]) & ow_ff) | ($past(line_out) & ~ow_ff)))
    else $error("output mask");
  chk_ow_read: assert property (
    acc_rd && paddr == gia_pkg::ADDR_OW_STATE
    |-> prdata[NUM_LINES-1:0] == ow_ff) else $error("mask read");
endmodule // gia_guard_sva
bind gia_guard gia_guard_sva #(.NUM_LINES(NUM_LINES)) i_sva (.pclk(pclk), .presetn(presetn),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .line_lock(line_lock), .line_out(line_out),
  .pull_down_en(pull_down_en));

// >>> tb/test_gpio_irq_mode_and_write_guard.sv
// Self-checking bench for the interrupt-mode and write-guard block
`timescale 1ns/1ns
module test_gpio_irq_mode_and_write_guard;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, irq;
  logic [31:0] paddr, pwdata, prdata, line_in, line_lock, line_out, pull_down_en;
  logic [31:0] drive_val, lock_val, lf, v, w;
  logic [32:0] exp_q[$];
  int          n_errors = 0;
  int          n_checks = 0;
  logic [31:0] set_a[3] = '{gia_pkg::ADDR_XMODE_SET, gia_pkg::ADDR_LEVEL_PICK,
                            gia_pkg::ADDR_HIGH_PICK};
  logic [31:0] clr_a[3] = '{gia_pkg::ADDR_XMODE_CLEAR, gia_pkg::ADDR_EDGE_PICK,
                            gia_pkg::ADDR_LOW_PICK};
  logic [31:0] st_a[3]  = '{gia_pkg::ADDR_XMODE_STATE, gia_pkg::ADDR_EL_STATE,
                            gia_pkg::ADDR_POL_STATE};
  logic [31:0] md[12]   = '{0, 0, 0, gia_pkg::ADDR_XMODE_SET, 0, gia_pkg::ADDR_HIGH_PICK, 0,
                            gia_pkg::ADDR_LEVEL_PICK, 0, 0, gia_pkg::ADDR_LOW_PICK, 0};
  logic [11:0] lv = 12'h729; // Line 0 level per step
  logic [11:0] le = 12'hb33; // Expected status bit per step
  gia_guard #(.NUM_LINES(32)) i_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .line_in(line_in), .line_lock(line_lock),
    .line_out(line_out), .pull_down_en(pull_down_en), .irq(irq));
  gia_pins i_pins (.pclk(pclk), .presetn(presetn), .drive_val(drive_val), .lock_val(lock_val),
    .line_in(line_in), .line_lock(line_lock));
  // ****************************************************************
  // Clock, helpers and bus tasks
  // ****************************************************************
  initial begin
    pclk = 1'b0;
    forever #20 pclk = ~pclk;
  end
  function automatic logic [31:0] nxt_rand(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic chk(input logic [32:0] got, input logic [32:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // Request held until pready is seen; one idle edge keeps strobes clean
  task automatic apb(input logic wr_en, input logic [31:0] a, input logic [31:0] d);
    psel <= 1'b1; penable <= 1'b0; pwrite <= wr_en; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    psel <= 1'b0; penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task automatic rd(input logic [31:0] a, input logic [31:0] e);
    exp_q.push_back({1'b0, e});
    apb(1'b0, a, 32'h0);
  endtask
  // Read results are paired with the oldest expectation
  always @(posedge pclk) begin
    if (psel && penable && !pwrite && exp_q.size() > 0) chk({pslverr, prdata}, exp_q.pop_front());
  end
  task automatic stop_test();
    $display("checks=%0d errors=%0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  // Hang guard, far beyond the few hundred cycles of the sequence
  initial begin
    #(40 * 20000);
    n_errors++;
    stop_test();
  end
  // ****************************************************************
  // Main sequence
  // ****************************************************************
  initial begin
    presetn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 32'h0; pwdata = 32'h0;
    drive_val = 32'h0; lock_val = 32'h0; lf = 32'd74;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    foreach (st_a[i]) rd(st_a[i], 32'h0);
    rd(gia_pkg::ADDR_OW_STATE, 32'h0);
    rd(gia_pkg::ADDR_GUARD_STATUS, 32'h0);
    chk({1'b0, pull_down_en}, {1'b0, 32'hffffffff});
    for (int i = 0; i < 3; i++) begin
      lf = nxt_rand(lf); v = lf; lf = nxt_rand(lf); w = lf;
      wr(set_a[i], v);
      rd(st_a[i], v);
      wr(clr_a[i], w);
      rd(st_a[i], v & ~w);
    end
    lf = nxt_rand(lf); v = lf; lf = nxt_rand(lf); w = lf;
    wr(gia_pkg::ADDR_OW_ENABLE, v);
    rd(gia_pkg::ADDR_OW_STATE, v);
    wr(gia_pkg::ADDR_OUT_DATA, w);
    chk({1'b0, line_out}, {1'b0, w & v});
    rd(gia_pkg::ADDR_OUT_DATA, w & v);
    wr(gia_pkg::ADDR_OW_DISABLE, w);
    rd(gia_pkg::ADDR_OW_STATE, v & ~w);
    lf = nxt_rand(lf); lock_val <= lf;
    wr(gia_pkg::ADDR_LOCK_STATE, ~lf);
    rd(gia_pkg::ADDR_LOCK_STATE, lf);
    exp_q.push_back({1'b1, 32'h0});
    apb(1'b0, 32'h400e0e9c, 32'h0);
    // Guard: bad key, good key, blocked writes, flag and source
    wr(gia_pkg::ADDR_PD_DISABLE, 32'hff);
    rd(gia_pkg::ADDR_PD_STATE, 32'h000000ff);
    chk({1'b0, pull_down_en}, {1'b0, 32'hffffff00});
    wr(gia_pkg::ADDR_GUARD_MODE, 32'h12345601);
    rd(gia_pkg::ADDR_GUARD_MODE, 32'h0);
    wr(gia_pkg::ADDR_GUARD_MODE, {gia_pkg::GUARD_KEY_VALUE, 8'h01});
    rd(gia_pkg::ADDR_GUARD_MODE, 32'h1);
    wr(gia_pkg::ADDR_PD_ENABLE, 32'h0f);
    chk({1'b0, pull_down_en}, {1'b0, 32'hffffff00});
    rd(gia_pkg::ADDR_GUARD_STATUS, 32'h00009401);
    rd(gia_pkg::ADDR_GUARD_STATUS, 32'h0);
    wr(gia_pkg::ADDR_OW_DISABLE, 32'hffffffff);
    rd(gia_pkg::ADDR_OW_STATE, v & ~w);
    rd(gia_pkg::ADDR_GUARD_STATUS, 32'h0000a401);
    wr(gia_pkg::ADDR_GUARD_MODE, {gia_pkg::GUARD_KEY_VALUE, 8'h00});
    rd(gia_pkg::ADDR_GUARD_MODE, 32'h0);
    wr(gia_pkg::ADDR_PD_ENABLE, 32'h0f);
    chk({1'b0, pull_down_en}, {1'b0, 32'hffffff0f});
    rd(gia_pkg::ADDR_PD_STATE, 32'h000000f0);
    // Interrupt modes on line 0; status cleared before every step
    wr(gia_pkg::ADDR_XMODE_CLEAR, 32'hffffffff);
    wr(gia_pkg::ADDR_EDGE_PICK, 32'h1);
    wr(gia_pkg::ADDR_LOW_PICK, 32'h1);
    wr(gia_pkg::ADDR_IRQ_ENABLE, 32'h1);
    for (int i = 0; i < 12; i++) begin
      if (md[i] != 32'h0) wr(md[i], 32'h1);
      wr(gia_pkg::ADDR_IRQ_CLEAR, 32'hffffffff);
      drive_val <= {31'h0, lv[i]};
      repeat (4) @(posedge pclk);
      chk({32'h0, irq}, {32'h0, le[i]});
      rd(gia_pkg::ADDR_IRQ_STATUS, {31'h0, le[i]});
    end
    wr(gia_pkg::ADDR_IRQ_ENABLE, 32'h0);
    chk({32'h0, irq}, 33'h0);
    stop_test();
  end
endmodule // test_gpio_irq_mode_and_write_guard
